//--- src/apd_host_port.sv
// ATA PIO device-side host port with APB register access
// Functional notes
// - register transfers use low data byte only
// - data port moves full 16-bit word
// - bit 15 is MSB, bit 0 LSB
// - write data taken on write strobe rise
// - read data driven from read strobe fall
// - negate ready to stretch host cycle
// - select low means master, high slave
// - interrupt pin floats when host disables it
// - status read end clears interrupt within 400ns
// - command write end clears interrupt within 400ns
// - 16-bit indicator low for word transfers
// - indicator high means 8-bit transfer
// - three address lines pick the register
// - cycles without chip select are ignored
// - slave signals diagnostics done to master
// - activity line shows active or present
`timescale 1ns/1ps
`default_nettype none

module apd_host_port
  import apd_pkg::*;
#(
  parameter int DW = 16,
  parameter int PRESENT_CYC = 1000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic host_rst_n,
  input wire logic [DW-1:0] hd_in,
  output logic [DW-1:0] hd_out,
  output logic hd_oe,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] ha,
  input wire logic csel,
  output logic iordy,
  output logic intrq_out,
  output logic intrq_oe,
  output logic iois16_n,
  input wire logic pdiag_n_in,
  output logic pdiag_n_out,
  output logic pdiag_n_oe,
  input wire logic dasp_n_in,
  output logic dasp_n_out,
  output logic dasp_n_oe
);
  // Clear window less the three-clock strobe synchroniser delay
  localparam int CLR_MAX = INTRQ_CLR_CYC - 3;

  // ****************************************
  // Host pin synchronisers
  // ****************************************
  logic [8:0] sy1_r, sy2_r;
  logic dior_q_r, diow_q_r;
  logic [DW-1:0] hd1_r, hd2_r, wr_lat_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
      dior_q_r <= 1'b1;
      diow_q_r <= 1'b1;
    end else begin
      sy1_r <= {csel, ha, cs1_n, cs0_n, diow_n, dior_n, host_rst_n};
      sy2_r <= sy1_r;
      dior_q_r <= sy2_r[1];
      diow_q_r <= sy2_r[2];
    end
  end
  // Data bus delayed alongside the strobes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hd1_r <= '0;
      hd2_r <= '0;
      wr_lat_r <= '0;
    end else begin
      hd1_r <= hd_in;
      hd2_r <= hd1_r;
      if (!sy2_r[2]) begin
        wr_lat_r <= hd2_r;
      end
    end
  end
  logic h_act, rd_l, wr_l, rd_fall, wr_rise, rd_rise, sel0, sel1, slave;
  logic is_data, is_stat, is_devctl;
  logic [2:0] ha_s;
  assign h_act = sy2_r[0];
  assign rd_l = ~sy2_r[1];
  assign wr_l = ~sy2_r[2];
  assign rd_fall = rd_l & dior_q_r;
  assign rd_rise = ~rd_l & ~dior_q_r;
  assign wr_rise = ~wr_l & ~diow_q_r;
  assign sel0 = ~sy2_r[3];
  assign sel1 = ~sy2_r[4];
  assign ha_s = sy2_r[7:5];
  assign slave = sy2_r[8];
  assign is_data = sel0 & ~sel1 & (ha_s == HA_DATA);
  assign is_stat = sel0 & ~sel1 & (ha_s == HA_STATUS);
  assign is_devctl = sel1 & ~sel0 & (ha_s == HA_DEVCTL);

  // ****************************************
  // Software registers
  // ****************************************
  logic [3:0] ctrl_r;
  logic [EV_W-1:0] irq_sts_r, irq_msk_r, ev;
  logic [7:0] tf_r [8];
  logic [DW-1:0] rd_data_r;
  logic [19:0] host_wr_r;
  logic rd_full_r, wr_full_r, intrq_pend_r, nien_r;
  logic acc, wr_acc, rd_acc, wide;
  logic [DW-1:0] wr_word;
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign wide = ctrl_r[CTRL_WIDE];
  assign wr_word = (is_data & wide) ? wr_lat_r : {8'h00, wr_lat_r[7:0]};
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      irq_msk_r <= MSK_RST;
    end else if (wr_acc && paddr == OFS_CTRL) begin
      ctrl_r <= pwdata[3:0] & ~(4'h1 << CTRL_IRQ_SET);
    end else if (wr_acc && paddr == OFS_IRQ_MSK) begin
      irq_msk_r <= pwdata[EV_W-1:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        tf_r[i] <= 8'h00;
      end
    end else if (wr_acc && paddr >= OFS_TF_BASE && paddr <= OFS_TF_LAST) begin
      tf_r[paddr[4:2]] <= pwdata[7:0];
    end
  end

  // ****************************************
  // Host cycle handling
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= '0;
      rd_full_r <= 1'b0;
    end else if (!h_act) begin
      rd_full_r <= 1'b0;
    end else if (wr_acc && paddr == OFS_RD_DATA) begin
      rd_data_r <= pwdata[DW-1:0];
      rd_full_r <= 1'b1;
    end else if (rd_rise && is_data) begin
      rd_full_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      host_wr_r <= '0;
      wr_full_r <= 1'b0;
      nien_r <= 1'b0;
    end else if (!h_act) begin
      wr_full_r <= 1'b0;
      nien_r <= 1'b0;
    end else if (wr_rise && (sel0 | sel1)) begin
      host_wr_r <= {sel1, ha_s, wr_word};
      wr_full_r <= 1'b1;
      if (is_devctl) begin
        nien_r <= wr_lat_r[DEVCTL_NIEN];
      end
    end else if (rd_acc && paddr == OFS_HOST_WR) begin
      wr_full_r <= 1'b0;
    end
  end
  // Set wins over clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intrq_pend_r <= 1'b0;
    end else if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_IRQ_SET]) begin
      intrq_pend_r <= 1'b1;
    end else if (!h_act) begin
      intrq_pend_r <= 1'b0;
    end else if (rd_rise && is_stat) begin
      intrq_pend_r <= 1'b0;
    end else if (wr_rise && is_stat) begin
      intrq_pend_r <= 1'b0;
    end
  end
  // Read word: data port full width, registers low byte
  logic [DW-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (is_data) begin
      rd_word = wide ? rd_data_r : {8'h00, rd_data_r[7:0]};
    end else if (sel0 & ~sel1) begin
      rd_word = {8'h00, tf_r[ha_s]};
    end else if (is_devctl) begin
      rd_word = {8'h00, tf_r[HA_STATUS]};
    end
  end
  logic [15:0] pres_cnt_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hd_out <= '0;
      hd_oe <= 1'b0;
      iordy <= 1'b1;
      iois16_n <= 1'b1;
      intrq_out <= 1'b0;
      intrq_oe <= 1'b0;
      pdiag_n_out <= 1'b1;
      pdiag_n_oe <= 1'b0;
      dasp_n_out <= 1'b1;
      dasp_n_oe <= 1'b0;
      pres_cnt_r <= '0;
    end else begin
      hd_out <= rd_word;
      hd_oe <= h_act & rd_l & (sel0 | sel1);
      iordy <= ~(h_act & is_data & ((rd_l & ~rd_full_r) |
                 (wr_l & wr_full_r)));
      iois16_n <= ~(h_act & is_data & wide);
      intrq_out <= intrq_pend_r;
      intrq_oe <= h_act & ~nien_r;
      pdiag_n_out <= ~(h_act & slave & ctrl_r[CTRL_DIAG_DONE]);
      pdiag_n_oe <= h_act & slave & ctrl_r[CTRL_DIAG_DONE];
      dasp_n_out <= ~(h_act & ((slave & pres_cnt_r != 0) |
                      ctrl_r[CTRL_ACTIVE]));
      dasp_n_oe <= h_act & ((slave & pres_cnt_r != 0) |
                   ctrl_r[CTRL_ACTIVE]);
      if (!h_act) begin
        pres_cnt_r <= 16'(PRESENT_CYC);
      end else if (pres_cnt_r != 0) begin
        pres_cnt_r <= pres_cnt_r - 16'h0001;
      end
    end
  end

  // ****************************************
  // Interrupt status and APB slave
  // ****************************************
  always_comb begin
    ev = '0;
    ev[EV_HOST_WR] = h_act & wr_rise & (sel0 | sel1);
    ev[EV_CMD] = h_act & wr_rise & is_stat;
    ev[EV_DATA_RD] = h_act & rd_rise & is_data;
    ev[EV_SRST] = h_act & wr_rise & is_devctl & wr_lat_r[DEVCTL_SRST];
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_sts_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_acc && paddr == OFS_IRQ_STS) begin
        irq_sts_r <= (irq_sts_r & ~pwdata[EV_W-1:0]) | ev;
      end else begin
        irq_sts_r <= irq_sts_r | ev;
      end
      irq <= |(irq_sts_r & irq_msk_r);
    end
  end
  logic [31:0] prdata_nxt;
  logic bad_nxt;
  always_comb begin
    prdata_nxt = '0;
    bad_nxt = 1'b0;
    if (paddr == OFS_CTRL) begin
      prdata_nxt[3:0] = ctrl_r;
    end else if (paddr == OFS_STAT) begin
      prdata_nxt[7:0] = {~dasp_n_in, ~pdiag_n_in, ~h_act, intrq_pend_r,
                         wr_full_r, rd_full_r, nien_r, slave};
    end else if (paddr == OFS_IRQ_STS) begin
      prdata_nxt[EV_W-1:0] = irq_sts_r;
    end else if (paddr == OFS_IRQ_MSK) begin
      prdata_nxt[EV_W-1:0] = irq_msk_r;
    end else if (paddr == OFS_HOST_WR) begin
      prdata_nxt[19:0] = host_wr_r;
    end else if (paddr == OFS_RD_DATA) begin
      prdata_nxt[DW-1:0] = rd_data_r;
    end else if (paddr >= OFS_TF_BASE && paddr <= OFS_TF_LAST) begin
      prdata_nxt[7:0] = tf_r[paddr[4:2]];
    end else begin
      bad_nxt = 1'b1;
    end
    if (paddr[1:0] != 2'b00) begin
      bad_nxt = 1'b1;
    end
  end
  // One wait state: answer registered in the first access cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? prdata_nxt : '0;
      pslverr <= psel & penable & ~pready & bad_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_rd_start;
    h_act & rd_fall & (sel0 | sel1);
  endsequence
  sequence s_stat_rd_end;
    h_act & rd_rise & is_stat & intrq_out;
  endsequence
  sequence s_cmd_wr_end;
    h_act & wr_rise & is_stat & intrq_out &
    !(wr_acc && paddr == OFS_CTRL && pwdata[CTRL_IRQ_SET]);
  endsequence

  a_reg_upper_zero: assert property (
    hd_oe && !$past(is_data) |-> hd_out[15:8] == 8'h00)
    else $error("register read drove upper byte");
  a_data_word: assert property (
    is_data && wide && h_act && rd_l && rd_full_r |=>
    hd_out == $past(rd_data_r))
    else $error("data word not driven");
  a_write_capture: assert property (
    h_act && wr_rise && is_data && wide |=> host_wr_r[15:0] == $past(wr_lat_r))
    else $error("write data not captured");
  a_read_drive: assert property (
    s_rd_start |=> hd_oe)
    else $error("read data not driven");
  a_iordy_hold: assert property (
    h_act && is_data && rd_l && !rd_full_r |=> !iordy)
    else $error("ready not negated");
  a_intrq_float: assert property (
    nien_r |=> !intrq_oe)
    else $error("interrupt pin driven while disabled");
  a_stat_clear: assert property (
    s_stat_rd_end and !(wr_acc && paddr == OFS_CTRL) |->
    ##[1:CLR_MAX] !intrq_out)
    else $error("interrupt not cleared after status read");
  a_cmd_clear: assert property (
    s_cmd_wr_end |-> ##[1:CLR_MAX] !intrq_out)
    else $error("interrupt not cleared after command write");
  a_word_flag: assert property (
    h_act && is_data && wide |=> !iois16_n)
    else $error("word indicator not low");
  a_diag_done: assert property (
    h_act && slave && ctrl_r[CTRL_DIAG_DONE] |=> pdiag_n_oe && !pdiag_n_out)
    else $error("diagnostic done not signalled");
  a_host_release: assert property (
    !h_act |=> !hd_oe && !intrq_oe && !pdiag_n_oe && !dasp_n_oe)
    else $error("outputs held during host reset");

endmodule

`default_nettype wire

//--- src/apd_pkg.sv
// Constants shared by the ATA PIO device host port
package apd_pkg;

  // ****************************************
  // APB register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;
  localparam logic [7:0] OFS_HOST_WR = 8'h10;
  localparam logic [7:0] OFS_RD_DATA = 8'h14;
  localparam logic [7:0] OFS_TF_BASE = 8'h20;
  localparam logic [7:0] OFS_TF_LAST = 8'h3C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_WIDE = 0;
  localparam int CTRL_IRQ_SET = 1;
  localparam int CTRL_DIAG_DONE = 2;
  localparam int CTRL_ACTIVE = 3;
  localparam int DEVCTL_NIEN = 1;
  localparam int DEVCTL_SRST = 2;
  localparam int EV_HOST_WR = 0;
  localparam int EV_CMD = 1;
  localparam int EV_DATA_RD = 2;
  localparam int EV_SRST = 3;
  localparam int EV_W = 4;

  // ****************************************
  // Host register selects
  // ****************************************
  localparam logic [2:0] HA_DATA = 3'h0;
  localparam logic [2:0] HA_DEVCTL = 3'h6;
  localparam logic [2:0] HA_STATUS = 3'h7;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [8:0] SYNC_RST = 9'h01F;
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [EV_W-1:0] MSK_RST = 4'h0;
  localparam int CLK_MHZ = 200;
  localparam int T_INTRQ_CLR_NS = 400;
  localparam int INTRQ_CLR_CYC = T_INTRQ_CLR_NS * CLK_MHZ / 1000;

endpackage

//--- verif/apd_host_model.sv
// Host PIO controller model driving the device strobes
`timescale 1ns/1ps
`default_nettype none

module apd_host_model (
  input wire logic clk,
  input wire logic iordy,
  input wire logic [15:0] bus,
  output logic [15:0] hd_drv,
  output logic dior_n,
  output logic diow_n,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] ha
);
  initial begin
    hd_drv = 16'h0000;
    dior_n = 1'b1;
    diow_n = 1'b1;
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    ha = 3'h0;
  end

  // Sel 0 picks CS0, 1 picks CS1, else none
  task automatic xfer(input logic wr, input logic [1:0] sel,
    input logic [2:0] adr, input logic [15:0] wd,
    output logic [15:0] rd);
    @(posedge clk);
    cs0_n <= (sel != 2'd0);
    cs1_n <= (sel != 2'd1);
    ha <= adr;
    hd_drv <= wr ? wd : ~hd_drv;
    repeat (2) @(posedge clk);
    if (wr)
      diow_n <= 1'b0;
    else
      dior_n <= 1'b0;
    repeat (5) @(posedge clk);
    while (iordy !== 1'b1) begin
      @(posedge clk);
    end
    repeat (5) @(posedge clk);
    rd = bus;
    dior_n <= 1'b1;
    diow_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Released bus shows the inverse, not a held value
    hd_drv <= ~hd_drv;
    cs0_n <= 1'b1;
    cs1_n <= 1'b1;
    ha <= ~adr;
    repeat (4) @(posedge clk);
  endtask
endmodule

`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the ATA PIO device host port
`timescale 1ns/1ps
`default_nettype none

module tb
  import apd_pkg::*;
;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic host_rst_n, csel, hd_oe, iordy, intrq_out, intrq_oe, iois16_n;
  logic [15:0] hd_in, hd_out, hd_drv, w;
  logic dior_n, diow_n, cs0_n, cs1_n, perr;
  logic [2:0] ha;
  logic pdiag_n_in, pdiag_n_out, pdiag_n_oe;
  logic dasp_n_in, dasp_n_out, dasp_n_oe;
  int bad_count, cmp_count, i;

  apd_host_port #(.DW(16), .PRESENT_CYC(10)) uut (
    .sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .host_rst_n, .hd_in, .hd_out,
    .hd_oe, .dior_n, .diow_n, .cs0_n, .cs1_n, .ha, .csel, .iordy,
    .intrq_out, .intrq_oe, .iois16_n, .pdiag_n_in, .pdiag_n_out,
    .pdiag_n_oe, .dasp_n_in, .dasp_n_out, .dasp_n_oe
  );
  apd_host_model hm (
    .clk(sys_clk), .iordy, .bus(hd_in), .hd_drv, .dior_n, .diow_n,
    .cs0_n, .cs1_n, .ha
  );

  // Host drives the data bus when the device releases it; pull-ups on the open-drain lines
  assign hd_in = hd_oe ? hd_out : hd_drv;
  assign pdiag_n_in = pdiag_n_oe ? pdiag_n_out : 1'b1;
  assign dasp_n_in = dasp_n_oe ? dasp_n_out : 1'b1;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ********************************
  // Bus and check tasks
  // ********************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    rstn = 1'b0;
    host_rst_n = 1'b0;
    csel = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    host_rst_n <= 1'b1;
    tick(4);
    check({29'h0, iordy, iois16_n, hd_oe}, 32'h6);
    rdm(OFS_CTRL, 32'hF, {28'h0, CTRL_RST});
    rdm(OFS_IRQ_MSK, 32'hF, 32'h0);
    rdm(8'h40, 32'hFFFFFFFF, 32'h0);
    check({31'h0, perr}, 32'h1);
    rdm(OFS_STAT, 32'h1, 32'h0);
    hm.xfer(1'b1, 2'd0, HA_DATA, 16'hA5C3, w);
    rdm(OFS_HOST_WR, 32'h000FFFFF, 32'h0000A5C3);
    rdm(OFS_IRQ_STS, 32'h1, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MSK, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STS, 32'h1);
    tick(2);
    check({31'h0, irq}, 32'h0);
    hm.xfer(1'b1, 2'd0, HA_DATA, 16'h1111, w);
    fork
      hm.xfer(1'b1, 2'd0, HA_DATA, 16'h2222, w);
      begin
        tick(30);
        check({31'h0, iordy}, 32'h0);
        rdm(OFS_HOST_WR, 32'hFFFF, 32'h1111);
      end
    join
    rdm(OFS_HOST_WR, 32'hFFFF, 32'h2222);
    wr(OFS_RD_DATA, 32'h8001);
    fork
      hm.xfer(1'b0, 2'd0, HA_DATA, 16'h0, w);
      begin
        tick(10);
        check({31'h0, iois16_n}, 32'h0);
      end
    join
    check({16'h0, w}, 32'h8001);
    check({31'h0, hd_oe}, 32'h0);
    rdm(OFS_IRQ_STS, 32'h4, 32'h4);
    fork
      hm.xfer(1'b0, 2'd0, HA_DATA, 16'h0, w);
      begin
        tick(20);
        check({31'h0, iordy}, 32'h0);
        wr(OFS_RD_DATA, 32'h5AA5);
      end
    join
    check({16'h0, w}, 32'h5AA5);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_RD_DATA, 32'hBEEF);
    fork
      hm.xfer(1'b0, 2'd0, HA_DATA, 16'h0, w);
      begin
        tick(10);
        check({31'h0, iois16_n}, 32'h1);
      end
    join
    check({16'h0, w}, 32'h00EF);
    for (i = 1; i < 7; i++) begin
      wr(OFS_TF_BASE + 8'(4 * i), 32'h30 + 32'(i));
      hm.xfer(1'b0, 2'd0, 3'(i), 16'h0, w);
      check({16'h0, w}, 32'h30 + 32'(i));
    end
    wr(OFS_TF_LAST, 32'h5A);
    hm.xfer(1'b0, 2'd1, HA_DEVCTL, 16'h0, w);
    check({16'h0, w}, 32'h5A);
    wr(OFS_IRQ_STS, 32'hF);
    fork
      hm.xfer(1'b0, 2'd2, HA_STATUS, 16'h0, w);
      begin
        tick(10);
        check({31'h0, hd_oe}, 32'h0);
      end
    join
    hm.xfer(1'b1, 2'd2, HA_DATA, 16'h7777, w);
    rdm(OFS_IRQ_STS, 32'hF, 32'h0);
    hm.xfer(1'b1, 2'd1, HA_DEVCTL, 16'h0000, w);
    wr(OFS_CTRL, 32'h3);
    tick(3);
    check({30'h0, intrq_oe, intrq_out}, 32'h3);
    hm.xfer(1'b0, 2'd0, HA_STATUS, 16'h0, w);
    check({31'h0, intrq_out}, 32'h0);
    wr(OFS_CTRL, 32'h3);
    tick(3);
    hm.xfer(1'b1, 2'd0, HA_STATUS, 16'h0020, w);
    check({31'h0, intrq_out}, 32'h0);
    rdm(OFS_IRQ_STS, 32'h2, 32'h2);
    hm.xfer(1'b1, 2'd1, HA_DEVCTL, 16'h0006, w);
    wr(OFS_CTRL, 32'h3);
    tick(3);
    check({31'h0, intrq_oe}, 32'h0);
    rdm(OFS_STAT, 32'h2, 32'h2);
    rdm(OFS_IRQ_STS, 32'h8, 32'h8);
    csel <= 1'b1;
    wr(OFS_CTRL, 32'hD);
    tick(4);
    rdm(OFS_STAT, 32'h1, 32'h1);
    check({30'h0, pdiag_n_oe, pdiag_n_out}, 32'h2);
    check({30'h0, dasp_n_oe, dasp_n_out}, 32'h2);
    rdm(OFS_STAT, 32'hC0, 32'hC0);
    wr(OFS_CTRL, 32'h5);
    host_rst_n <= 1'b0;
    tick(4);
    check({28'h0, hd_oe, intrq_oe, pdiag_n_oe, dasp_n_oe}, 32'h0);
    check({30'h0, iordy, iois16_n}, 32'h3);
    rdm(OFS_STAT, 32'h20, 32'h20);
    host_rst_n <= 1'b1;
    tick(4);
    check({30'h0, dasp_n_oe, dasp_n_out}, 32'h2);
    tick(12);
    check({30'h0, dasp_n_oe, dasp_n_out}, 32'h1);
    report_and_stop;
  end
endmodule

`default_nettype wire
